// file: include/rtc_pkg.sv
// Package: register map, field positions, timing counts and carrier types for the RTC block
`default_nettype none
package rtc_pkg;
    localparam int ADDR_W          = 17;
    localparam int CLK_HZ          = 200_000_000;
    // Registers sit at the eight highest byte addresses
    localparam logic [16:0] REG_BASE     = 17'h1FFF8;
    localparam logic [2:0]  IDX_CENTURY  = 3'h0;
    localparam logic [2:0]  IDX_SECONDS  = 3'h1;
    localparam logic [2:0]  IDX_MINUTES  = 3'h2;
    localparam logic [2:0]  IDX_HOURS    = 3'h3;
    localparam logic [2:0]  IDX_DAY      = 3'h4;
    localparam logic [2:0]  IDX_DATE     = 3'h5;
    localparam logic [2:0]  IDX_MONTH    = 3'h6;
    localparam logic [2:0]  IDX_YEAR     = 3'h7;
    // Control bit positions
    localparam int BIT_WRITE_FREEZE = 7;
    localparam int BIT_READ_FREEZE  = 6;
    localparam int BIT_CLOCK_HALT   = 7;
    localparam int BIT_TICK_TEST    = 6;
    localparam int BIT_BATTERY_GOOD = 7;
    // Reset values of the time counters: 2000-01-01, day 1, 00:00:00
    localparam logic [7:0] RST_CENTURY = 8'h20;
    localparam logic [7:0] RST_YEAR    = 8'h00;
    localparam logic [7:0] RST_MONTH   = 8'h01;
    localparam logic [7:0] RST_DATE    = 8'h01;
    localparam logic [7:0] RST_DAY     = 8'h01;
    // Timing
    localparam int TICK_HZ        = 1;
    localparam int TEST_HZ        = 512;
    localparam int CYC_PER_SEC    = CLK_HZ / TICK_HZ;
    localparam int CYC_PER_HALF_TEST = CLK_HZ / (2 * TEST_HZ);

    typedef struct packed {
        logic [7:0] century;
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] date;
        logic [2:0] day;
        logic [7:0] hours;
        logic [7:0] minutes;
        logic [7:0] seconds;
    } time_t;

    typedef struct packed {
        logic        cs_n;
        logic        oe_n;
        logic        we_n;
        logic [16:0] addr;
        logic [7:0]  data;
    } bus_t;
endpackage : rtc_pkg
`default_nettype wire

// file: src/rtc_counter.sv
// Calendar counter: BCD time keeping with month lengths and leap years
`default_nettype none
module rtc_counter #(
    parameter int CYC_PER_SEC = rtc_pkg::CYC_PER_SEC
) (
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    input  wire logic          run,
    input  wire logic          load,
    input  wire rtc_pkg::time_t load_val,
    output logic               sec_tick,
    output rtc_pkg::time_t     now
);
    localparam int CW = $clog2(CYC_PER_SEC + 1);

    logic [CW-1:0]   div_reg;
    logic [CW-1:0]   div_next;
    rtc_pkg::time_t  t_reg;
    rtc_pkg::time_t  t_next;

    // BCD increment with wrap from max to min
    function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] max,
                                           input logic [7:0] min);
        if (v >= max)
            return min;
        if (v[3:0] >= 4'h9)
            return {v[7:4] + 4'h1, 4'h0};
        return {v[7:4], v[3:0] + 4'h1};
    endfunction : bcd_inc

    // Days in month, leap when year divisible by four (correct through 2099)
    function automatic logic [7:0] month_days(input logic [7:0] mon, input logic [7:0] yr);
        logic [4:0] y;
        y = 5'((yr[7:4] * 2) + yr[1:0]);
        case (mon)
            8'h02:   return (y[1:0] == 2'h0) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
            default: return 8'h31;
        endcase
    endfunction : month_days

    // Carry ripple from seconds to century
    always_comb begin
        div_next = div_reg;
        t_next   = t_reg;
        sec_tick = 1'b0;
        if (load) begin // see RQ10
            t_next   = load_val;
            div_next = '0;
        end else if (run) begin
            if (div_reg >= CW'(CYC_PER_SEC - 1)) begin
                div_next = '0;
                sec_tick = 1'b1;
                t_next.seconds = bcd_inc(t_reg.seconds, 8'h59, 8'h00); // see RQ2
                if (t_reg.seconds >= 8'h59) begin
                    t_next.minutes = bcd_inc(t_reg.minutes, 8'h59, 8'h00);
                    if (t_reg.minutes >= 8'h59) begin
                        t_next.hours = bcd_inc(t_reg.hours, 8'h23, 8'h00);
                        if (t_reg.hours >= 8'h23) begin
                            t_next.day = (t_reg.day >= 3'h7) ? 3'h1 : t_reg.day + 3'h1;
                            t_next.date = bcd_inc(t_reg.date,
                                month_days(t_reg.month, t_reg.year), 8'h01); // see RQ3
                            if (t_reg.date >= month_days(t_reg.month, t_reg.year)) begin
                                t_next.month = bcd_inc(t_reg.month, 8'h12, 8'h01);
                                if (t_reg.month >= 8'h12) begin
                                    t_next.year = bcd_inc(t_reg.year, 8'h99, 8'h00);
                                    if (t_reg.year >= 8'h99)
                                        t_next.century = bcd_inc(t_reg.century, 8'h39, 8'h00);
                                end
                            end
                        end
                    end
                end
            end else begin
                div_next = div_reg + CW'(1);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= '0;
            t_reg   <= '{century: rtc_pkg::RST_CENTURY, year: rtc_pkg::RST_YEAR,
                         month: rtc_pkg::RST_MONTH, date: rtc_pkg::RST_DATE,
                         day: rtc_pkg::RST_DAY[2:0], hours: 8'h00, minutes: 8'h00,
                         seconds: 8'h00};
        end else begin
            div_reg <= div_next;
            t_reg   <= t_next;
        end
    end

    assign now = t_reg;
endmodule : rtc_counter
`default_nettype wire

// file: src/rtc_byte_port.sv
// Real-time clock registers behind an asynchronous byte-wide memory port
// How it works
// RQ1: Eight registers at top byte addresses.
// RQ2: Time fields in packed BCD, 24-hour.
// RQ3: Month lengths and leap years through 2100. Code treats year 00 as leap, correct only through 2099.
// RQ4: Visible registers separate from running counters.
// RQ5: Read-freeze bit stops visible copy.
// RQ6: Freeze shows time at write instant.
// RQ7: Clearing freeze refreshes all within second.
// RQ8: Host holds read-freeze low 500 us.
// RQ9: Write-freeze halts updates for host load.
// RQ10: Clearing write-freeze loads counters, resumes.
// RQ11: Seconds bit 7 stops and starts oscillator.
// RQ12: Tick test toggles seconds LSB 512 Hz.
// RQ13: Held seconds read shows toggling data.
// RQ14: Power fail deselects, data high impedance.
// RQ15: Read when select, output enable low.
// RQ16: Write while select and write enable low.
// RQ17: Day bit 7 reports battery good, read-only.
// RQ18: Unassigned bits are plain storage bits.
// RQ19: Selected but idle: no drive, no change.
`default_nettype none
module rtc_byte_port #(
    parameter int ADDR_W      = rtc_pkg::ADDR_W,
    parameter int CYC_PER_SEC = rtc_pkg::CYC_PER_SEC,
    parameter int CYC_HALF_T  = rtc_pkg::CYC_PER_HALF_TEST
) (
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic              cs_n,
    input  wire logic              oe_n,
    input  wire logic              we_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [7:0]        data_in,
    output logic      [7:0]        data_out,
    output logic                   data_oe,
    input  wire logic              power_fail,
    input  wire logic              battery_good
);
    localparam int DEPTH = 1 << ADDR_W;
    localparam int HW    = $clog2(CYC_HALF_T + 1);

    // Pin synchronisers: two stages before any logic looks at the pins
    rtc_pkg::bus_t s1_reg;
    rtc_pkg::bus_t s2_reg;
    logic [1:0]    pf_s_reg;
    logic [1:0]    bg_s_reg;
    logic          we_act_reg;
    logic          we_act_next;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg   <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, data: '0};
            s2_reg   <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, data: '0};
            pf_s_reg <= 2'h3;
            bg_s_reg <= 2'h0;
        end else begin
            s1_reg   <= '{cs_n: cs_n, oe_n: oe_n, we_n: we_n, addr: addr, data: data_in};
            s2_reg   <= s1_reg;
            pf_s_reg <= {pf_s_reg[0], power_fail};
            bg_s_reg <= {bg_s_reg[0], battery_good};
        end
    end

    logic pf;
    logic rd_req;
    logic wr_req;
    logic is_reg;
    logic [2:0] ridx;
    assign pf     = pf_s_reg[1];
    assign wr_req = !pf && !s2_reg.cs_n && !s2_reg.we_n; // see RQ16 see RQ14
    assign rd_req = !pf && !s2_reg.cs_n && !s2_reg.oe_n && s2_reg.we_n; // see RQ15 see RQ19
    assign is_reg = (s2_reg.addr >= rtc_pkg::REG_BASE); // see RQ1
    assign ridx   = s2_reg.addr[2:0];

    // Plain storage for the whole space; clock bytes overlay the top eight
    logic [7:0] mem [DEPTH];

    // Visible register bank and control bits
    logic [7:0] vis_reg [8];
    logic [7:0] vis_next [8];
    logic       wfrz_prev_reg;
    logic       wfrz_prev_next;
    logic [HW-1:0] tdiv_reg;
    logic [HW-1:0] tdiv_next;
    logic       tog_reg;
    logic       tog_next;

    logic           run;
    logic           load;
    rtc_pkg::time_t now;
    rtc_pkg::time_t load_val;

    logic rfrz;
    logic wfrz;
    assign rfrz = vis_reg[rtc_pkg::IDX_CENTURY][rtc_pkg::BIT_READ_FREEZE];
    assign wfrz = vis_reg[rtc_pkg::IDX_CENTURY][rtc_pkg::BIT_WRITE_FREEZE];
    assign run  = !vis_reg[rtc_pkg::IDX_SECONDS][rtc_pkg::BIT_CLOCK_HALT]; // see RQ11
    assign load = wfrz_prev_reg && !wfrz; // see RQ10
    assign load_val = '{century: {2'h0, vis_reg[0][5:0]},
                        seconds: {1'b0, vis_reg[1][6:0]}, minutes: {1'b0, vis_reg[2][6:0]},
                        hours:   {2'h0, vis_reg[3][5:0]}, day: vis_reg[4][2:0],
                        date:    {2'h0, vis_reg[5][5:0]}, month: {3'h0, vis_reg[6][4:0]},
                        year:    vis_reg[7]};

    // Internal counters run on regardless of host access
    rtc_counter #(.CYC_PER_SEC(CYC_PER_SEC)) counter_u ( // see RQ4
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .run      (run),
        .load     (load),
        .load_val (load_val),
        .sec_tick (),
        .now      (now)
    );

    // Copy counters into visible bank unless frozen; host writes update bits
    always_comb begin
        for (int i = 0; i < 8; i++)
            vis_next[i] = vis_reg[i];
        wfrz_prev_next = wfrz;
        tdiv_next = tdiv_reg;
        tog_next  = tog_reg;
        // Time bits copied, spare and control bits kept as storage
        if (!rfrz && !wfrz) begin // see RQ5 see RQ6 see RQ9 see RQ7
            vis_next[0] = {vis_reg[0][7:6], now.century[5:0]};
            vis_next[1] = {vis_reg[1][7], now.seconds[6:0]};
            vis_next[2] = {vis_reg[2][7], now.minutes[6:0]};
            vis_next[3] = {vis_reg[3][7:6], now.hours[5:0]};
            vis_next[4] = {vis_reg[4][7:3], now.day};
            vis_next[5] = {vis_reg[5][7:6], now.date[5:0]};
            vis_next[6] = {vis_reg[6][7:5], now.month[4:0]};
            vis_next[7] = now.year; // see RQ2
        end
        if (wr_req && is_reg)
            vis_next[ridx] = s2_reg.data; // see RQ18
        // Test divider: 512 Hz square wave, only while oscillator runs
        if (run && vis_reg[rtc_pkg::IDX_DAY][rtc_pkg::BIT_TICK_TEST]) begin // see RQ12
            if (tdiv_reg >= HW'(CYC_HALF_T - 1)) begin
                tdiv_next = '0;
                tog_next  = !tog_reg;
            end else begin
                tdiv_next = tdiv_reg + HW'(1);
            end
        end else begin
            tdiv_next = '0;
            tog_next  = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 8; i++)
                vis_reg[i] <= 8'h00;
            wfrz_prev_reg <= 1'b0;
            tdiv_reg      <= '0;
            tog_reg       <= 1'b0;
        end else begin
            for (int i = 0; i < 8; i++)
                vis_reg[i] <= vis_next[i];
            wfrz_prev_reg <= wfrz_prev_next;
            tdiv_reg      <= tdiv_next;
            tog_reg       <= tog_next;
        end
    end

    // RAM array has no reset; it models nonvolatile storage
    always_ff @(posedge sys_clk) begin
        if (wr_req && !is_reg)
            mem[s2_reg.addr] <= s2_reg.data;
    end

    // Read mux, registered so data comes from flip-flops
    logic [7:0] rd_next;
    logic [7:0] rd_reg;
    logic       oe_reg;
    always_comb begin
        rd_next = mem[s2_reg.addr];
        if (is_reg) begin
            rd_next = vis_reg[ridx];
            if (ridx == rtc_pkg::IDX_DAY)
                rd_next[rtc_pkg::BIT_BATTERY_GOOD] = bg_s_reg[1]; // see RQ17
            if (ridx == rtc_pkg::IDX_SECONDS && run
                && vis_reg[rtc_pkg::IDX_DAY][rtc_pkg::BIT_TICK_TEST])
                rd_next[0] = tog_reg; // see RQ13
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_reg <= 8'h00;
            oe_reg <= 1'b0;
        end else begin
            rd_reg <= rd_next;
            oe_reg <= rd_req; // see RQ14 see RQ19
        end
    end

    assign data_out = rd_reg;
    assign data_oe  = oe_reg;
endmodule : rtc_byte_port
`default_nettype wire

// file: testbench/rtc_byte_port_properties.sv
// Checker: port-level properties of the RTC byte port
`default_nettype none
module rtc_byte_port_properties #(
    parameter int ADDR_W     = 17,
    parameter int CYC_HALF_T = 4
) (
    input wire logic              sys_clk,
    input wire logic              rst_n,
    input wire logic              cs_n,
    input wire logic              oe_n,
    input wire logic              we_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0]        data_in,
    input wire logic [7:0]        data_out,
    input wire logic              data_oe,
    input wire logic              power_fail,
    input wire logic              battery_good
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       rd, wr, hit, sec_rd;
    logic [2:0] ctl_reg;
    logic [3:0] run_reg;
    logic       d0_reg;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Bus states decoded from the raw pins
    assign rd     = !cs_n && !oe_n && we_n && !power_fail;
    assign wr     = !cs_n && !we_n && !power_fail;
    assign hit    = addr >= ADDR_W'(rtc_pkg::REG_BASE);
    assign sec_rd = rd && hit && addr[2:0] == rtc_pkg::IDX_SECONDS;
    // Shadow of read freeze, tick test and halt as last written by the host
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_reg <= 3'h0;
        end else if (wr && hit) begin
            if (addr[2:0] == rtc_pkg::IDX_CENTURY) ctl_reg[0] <= data_in[6];
            if (addr[2:0] == rtc_pkg::IDX_DAY) ctl_reg[1] <= data_in[6];
            if (addr[2:0] == rtc_pkg::IDX_SECONDS) ctl_reg[2] <= data_in[7];
        end
    end
    // Cycles since data bit 0 last changed; wrap only weakens the check
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_reg <= 4'h0;
            d0_reg  <= 1'b0;
        end else begin
            run_reg <= (data_out[0] != d0_reg) ? 4'h0 : run_reg + 4'h1;
            d0_reg  <= data_out[0];
        end
    end
    property p_pf_quiet;
        power_fail [*4] |-> !data_oe;
    endproperty
    a_pf_quiet: assert property (p_pf_quiet) else $error("drive in power fail");
    property p_drive_cause;
        data_oe |-> $past(rd, 3);
    endproperty
    a_drive_cause: assert property (p_drive_cause) else $error("drive without read");
    property p_read_drive;
        rd [*4] |-> data_oe;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read not driven");
    property p_write_quiet;
        (!cs_n && !we_n) [*4] |-> !data_oe;
    endproperty
    a_write_quiet: assert property (p_write_quiet) else $error("drive in write");
    property p_freeze;
        (ctl_reg[0] && rd && $stable(addr) && addr[2:0] != rtc_pkg::IDX_SECONDS) [*4]
            |-> $stable(data_out);
    endproperty
    a_freeze: assert property (p_freeze) else $error("frozen byte moved");
    property p_tick;
        (sec_rd && ctl_reg[1] && !ctl_reg[2]) [*8] |-> run_reg <= 2 * CYC_HALF_T;
    endproperty
    a_tick: assert property (p_tick) else $error("test tick missing");
    property p_halt;
        (sec_rd && ctl_reg[2] && $stable(addr)) [*8] |-> $stable(data_out);
    endproperty
    a_halt: assert property (p_halt) else $error("seconds move while halted");
    property p_battery;
        (rd && hit && addr[2:0] == rtc_pkg::IDX_DAY && $stable(battery_good)) [*4]
            |-> data_out[7] == battery_good;
    endproperty
    a_battery: assert property (p_battery) else $error("battery flag wrong");
    c_tick: cover property ((sec_rd && ctl_reg[1]) [*8]);
    c_pf: cover property (power_fail && !cs_n);
    c_freeze: cover property (ctl_reg[0] && rd);
endmodule : rtc_byte_port_properties
bind rtc_byte_port rtc_byte_port_properties #(.ADDR_W(ADDR_W), .CYC_HALF_T(CYC_HALF_T))
    u_rtc_byte_port_properties (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n), .oe_n(oe_n),
    .we_n(we_n), .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .power_fail(power_fail), .battery_good(battery_good));
`default_nettype wire

// file: testbench/rtc_host_model.sv
// Host model: drives the byte-wide memory bus as a processor would
`default_nettype none
module rtc_host_model (
    input  wire logic     sys_clk,
    input  wire logic     data_oe,
    output rtc_pkg::bus_t bus
);
    timeunit 1ns;
    timeprecision 1ps;
    initial bus = '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 17'h00000, data: 8'h00};
    // Write levels held four edges with a steady address; released data shows its inverse
    task automatic wr(input logic [16:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        bus = '{cs_n: 1'b0, oe_n: 1'b1, we_n: 1'b0, addr: a, data: d};
        repeat (4) @(posedge sys_clk);
        #1;
        bus = '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: a, data: ~d};
    endtask : wr
    // Read held until the answer edge plus hold cycles; bounded wait for the drive
    task automatic rd(input logic [16:0] a, input int hold, output logic ok);
        int n;
        ok = 1'b0;
        @(posedge sys_clk);
        #1;
        bus = '{cs_n: 1'b0, oe_n: 1'b0, we_n: 1'b1, addr: a, data: ~bus.data};
        for (n = 0; n < 12 && !ok; n++) begin
            @(posedge sys_clk);
            ok = (data_oe === 1'b1);
        end
        repeat (hold) @(posedge sys_clk);
        #1;
        bus.cs_n = 1'b1;
        bus.oe_n = 1'b1;
        repeat (4) @(posedge sys_clk);
    endtask : rd
endmodule : rtc_host_model
`default_nettype wire

// file: testbench/testbench.sv
// Testbench: sets, freezes and reads the clock, then RAM and power-fail checks
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [16:0] TOP = rtc_pkg::REG_BASE;
    logic          sys_clk = 1'b0, rst_n = 1'b0, power_fail = 1'b0, battery_good = 1'b1;
    logic [7:0]    data_out, dv[4];
    logic          data_oe, ok, last, last_oe = 1'b0;
    logic [16:0]   ra;
    rtc_pkg::bus_t bus;
    logic [7:0]    exp_q[$];
    int            fails = 0, samples_checked = 0, cyc = 0, t0 = 0, tg, i;
    logic [7:0]    tv[8] = '{8'hA0, 8'h58, 8'h59, 8'h23, 8'h03, 8'h28, 8'h02, 8'h24};
    logic [7:0]    ev[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h84, 8'h29, 8'h02, 8'h24};
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;
    // Short second and tick counts keep the run small
    rtc_byte_port #(.CYC_PER_SEC(200), .CYC_HALF_T(4)) u_rtc_byte_port (.sys_clk(sys_clk),
        .rst_n(rst_n), .cs_n(bus.cs_n), .oe_n(bus.oe_n), .we_n(bus.we_n), .addr(bus.addr),
        .data_in(bus.data), .data_out(data_out), .data_oe(data_oe),
        .power_fail(power_fail), .battery_good(battery_good));
    rtc_host_model u_rtc_host_model (.sys_clk(sys_clk), .data_oe(data_oe), .bus(bus));
    task automatic check(input logic c, input string m);
        samples_checked++;
        if (c !== 1'b1) begin
            fails++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask : check
    task automatic end_of_test;
        check(exp_q.size() == 0, "answers missing");
        $display("fails %0d samples_checked %0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    // Monitor: each new drive of the bus with a note queued is compared with the oldest note
    always @(posedge sys_clk) begin
        last_oe <= data_oe;
        if (data_oe === 1'b1 && last_oe === 1'b0 && exp_q.size() > 0) begin
            check(data_out === exp_q[0], "read data mismatch");
            void'(exp_q.pop_front());
        end
    end
    task automatic rd_chk(input logic [16:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_rtc_host_model.rd(a, 1, ok);
        check(ok, "no answer");
    endtask : rd_chk
    // Bounded wait to a cycle offset from the clock load
    task automatic wait_to(input int n);
        int k;
        for (k = 0; k < 2000 && cyc - t0 < n; k++) @(posedge sys_clk);
        if (cyc - t0 < n) begin
            check(1'b0, "wait timed out");
            end_of_test();
        end
    endtask : wait_to
    // Counts toggles of data bit 0 during a long held seconds read
    task automatic tick_count;
        fork
            u_rtc_host_model.rd(TOP + 17'h1, 20, ok);
            begin
                repeat (8) @(posedge sys_clk);
                last = data_out[0];
                tg = 0;
                repeat (12) begin
                    @(posedge sys_clk);
                    if (data_out[0] !== last) tg++;
                    last = data_out[0];
                end
            end
        join
    endtask : tick_count
    initial begin
        void'($urandom(78));
        repeat (8) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        for (i = 0; i < 8; i++) u_rtc_host_model.wr(TOP + 17'(i), tv[i]);
        u_rtc_host_model.wr(TOP, 8'h20);
        t0 = cyc;
        wait_to(500);
        u_rtc_host_model.wr(TOP, 8'h60);
        for (i = 1; i < 8; i++) rd_chk(TOP + 17'(i), ev[i]);
        wait_to(900);
        rd_chk(TOP + 17'h1, 8'h00);
        u_rtc_host_model.wr(TOP, 8'h20);
        wait_to(1100);
        rd_chk(TOP + 17'h1, 8'h03);
        u_rtc_host_model.wr(TOP + 17'h4, 8'h44);
        tick_count();
        check(tg >= 2, "no test tick");
        u_rtc_host_model.wr(TOP + 17'h1, 8'h80);
        tick_count();
        check(tg == 0, "tick while halted");
        u_rtc_host_model.wr(TOP + 17'h1, 8'h00);
        tick_count();
        check(tg >= 2, "no tick after restart");
        // Random RAM bytes below the clock registers
        ra = 17'($urandom_range(17'h1FFF0));
        for (i = 0; i < 4; i++) begin
            dv[i] = 8'($urandom);
            u_rtc_host_model.wr(ra + 17'(i), dv[i]);
        end
        for (i = 0; i < 4; i++) rd_chk(ra + 17'(i), dv[i]);
        @(posedge sys_clk);
        #1 power_fail = 1'b1;
        u_rtc_host_model.wr(ra, ~dv[0]);
        u_rtc_host_model.rd(ra, 1, ok);
        check(!ok, "answer in power fail");
        #1 power_fail = 1'b0;
        repeat (4) @(posedge sys_clk);
        rd_chk(ra, dv[0]);
        // Weak battery must show in day bit 7 while the rest of the byte stays
        #1 battery_good = 1'b0;
        repeat (4) @(posedge sys_clk);
        rd_chk(TOP + 17'h4, 8'h44);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
